// ===== pkg/dps_pkg.sv
// Package: constants and types for the memory power and refresh sequencer
package dps_pkg;
    // Two-part command codes on chip select (active low) and function control
    localparam logic       CS_SEL       = 1'b0;
    localparam logic       CS_DESEL     = 1'b1;
    localparam logic       FN_READ_ACT  = 1'b1;   // first command: read-activate
    localparam logic       FN_WRITE_ACT = 1'b0;   // first command: write-activate
    localparam logic       FN_LAL       = 1'b1;   // second command: lower address latch
    localparam logic       FN_REF       = 1'b0;   // second command: refresh / mode load
    // Extended mode load selects
    localparam logic [1:0] BANK_REGULAR = 2'h0;
    localparam logic [1:0] BANK_EXT     = 2'h1;
    localparam int         DLL_BIT      = 0;
    // Timing in the clock domain
    localparam int         CLK_PERIOD_PS        = 20000;
    localparam int         REFRESH_INTERVAL_PS  = 3900000;
    localparam int         REFRESH_INTERVAL_CYC = REFRESH_INTERVAL_PS / CLK_PERIOD_PS;
    localparam int         REFRESH_CYCLE_CL4    = 19;
    localparam int         WRITE_EXTRA_CYC      = 2;
    localparam int         REFRESH_AVG_WINDOW   = 8;
    localparam int         CNT_W                = 16;
    // Software register offsets
    localparam logic [3:0] REG_CTRL       = 4'h0;
    localparam logic [3:0] REG_STATUS     = 4'h1;
    localparam logic [3:0] REG_CMD        = 4'h2;
    localparam logic [3:0] REG_T_REFC     = 4'h3;
    localparam logic [3:0] REG_T_PDA      = 4'h4;
    localparam logic [3:0] REG_T_LOCK     = 4'h5;
    localparam logic [3:0] REG_T_RSC      = 4'h6;
    localparam logic [3:0] REG_T_WINDOW   = 4'h7;
    localparam logic [3:0] REG_T_CKD      = 4'h8;
    localparam logic [3:0] REG_LAT        = 4'h9;
    localparam logic [3:0] REG_EXT_DATA   = 4'hA;
    // Command register codes
    localparam logic [2:0] OP_NONE      = 3'h0;
    localparam logic [2:0] OP_READ      = 3'h1;
    localparam logic [2:0] OP_WRITE     = 3'h2;
    localparam logic [2:0] OP_REFRESH   = 3'h3;
    localparam logic [2:0] OP_MODE      = 3'h4;
    localparam logic [2:0] OP_EXT_MODE  = 3'h5;
    localparam logic [2:0] OP_POWERDOWN = 3'h6;
    localparam logic [2:0] OP_SELFREF   = 3'h7;
    // Reset values
    localparam logic [15:0] T_REFC_RST   = 16'h0013;
    localparam logic [15:0] T_PDA_RST    = 16'h0004;
    localparam logic [15:0] T_LOCK_RST   = 16'h00C8;
    localparam logic [15:0] T_RSC_RST    = 16'h0004;
    localparam logic [15:0] T_WINDOW_RST = 16'h0002;
    localparam logic [15:0] T_CKD_RST    = 16'h0004;
    localparam logic [15:0] LAT_RST      = 16'h0024; // burst/2=2, read latency=4
    typedef enum logic [2:0] {
        DPS_IDLE  = 3'b000,
        DPS_FIRST = 3'b001,
        DPS_SECND = 3'b011,
        DPS_PDOWN = 3'b010,
        DPS_SREF  = 3'b110,
        DPS_WAIT  = 3'b111
    } dps_state_t;
endpackage

// ===== logic/dps_ctrl.sv
// Host sequencer: two-part commands, power-down, self-refresh and refresh pacing
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
module dps_ctrl
    import dps_pkg::*;
#(
    parameter int REFRESH_INTERVAL = REFRESH_INTERVAL_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             mem_clk_en,
    output logic             chip_select_n,
    output logic             function_control,
    output logic      [1:0]  bank_addr,
    output logic      [14:0] mem_addr,
    output logic             low_power_request_n,
    output logic             write_strobe_in,
    output logic             write_strobe_oe
);
    // ==========================================================
    // Software registers
    logic [2:0]  op_r;
    logic        op_pend_r;
    logic [14:0] cmd_upper_r;
    logic [14:0] cmd_lower_r;
    logic [1:0]  cmd_bank_r;
    logic [15:0] t_refc_r, t_pda_r, t_lock_r, t_rsc_r, t_window_r, t_ckd_r, lat_r;
    logic [14:0] ext_data_r;
    logic        auto_ref_en_r;
    logic        clk_stop_r;
    logic        op_taken;
    logic [31:0] rdata_nxt;

    wire [3:0] read_lat  = lat_r[3:0];
    // Write latency follows read latency, one cycle shorter
    wire [3:0] write_lat = lat_r[3:0] - 4'h1;
    wire [3:0] half_bl   = lat_r[7:4];

    // New timing values affect holds loaded after the write; t_pda_r and half_bl are also compared live against refi_r and burst_r
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            t_refc_r      <= T_REFC_RST;
            t_pda_r       <= T_PDA_RST;
            t_lock_r      <= T_LOCK_RST;
            t_rsc_r       <= T_RSC_RST;
            t_window_r    <= T_WINDOW_RST;
            t_ckd_r       <= T_CKD_RST;
            lat_r         <= LAT_RST;
            ext_data_r    <= 15'h0000;
            auto_ref_en_r <= 1'b0;
            clk_stop_r    <= 1'b0;
            cmd_upper_r   <= 15'h0000;
            cmd_lower_r   <= 15'h0000;
            cmd_bank_r    <= 2'h0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                REG_CTRL: begin
                    auto_ref_en_r <= reg_wdata[0];
                    clk_stop_r    <= reg_wdata[1];
                end
                REG_CMD: begin
                    // Address fields of a pending command must not move under it
                    if (!op_pend_r) begin
                        cmd_upper_r <= reg_wdata[18:4];
                        cmd_lower_r <= {8'h00, reg_wdata[25:19]};
                        cmd_bank_r  <= reg_wdata[27:26];
                    end
                end
                REG_T_REFC:   t_refc_r   <= reg_wdata[15:0];
                REG_T_PDA:    t_pda_r    <= reg_wdata[15:0];
                REG_T_LOCK:   t_lock_r   <= reg_wdata[15:0];
                REG_T_RSC:    t_rsc_r    <= reg_wdata[15:0];
                REG_T_WINDOW: t_window_r <= reg_wdata[15:0];
                REG_T_CKD:    t_ckd_r    <= reg_wdata[15:0];
                REG_LAT:      lat_r      <= reg_wdata[15:0];
                // DLL switch forced to enabled for normal operation
                REG_EXT_DATA: ext_data_r <= {reg_wdata[14:1], 1'b0};
                default: ;
            endcase
        end
    end

    // Command request; pending flag set by software wins over completion
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            op_r      <= OP_NONE;
            op_pend_r <= 1'b0;
        end else if (reg_wr && reg_addr == REG_CMD && !op_pend_r) begin
            // A no-op word is the wake-up order, so it only counts while the pin is low
            op_r      <= reg_wdata[2:0];
            op_pend_r <= reg_wdata[2:0] != OP_NONE || !low_power_request_n;
        end else if (op_taken || (op_r == OP_NONE && low_power_request_n)) begin
            // The wake-up order retires once the pin is back high
            op_pend_r <= 1'b0;
        end
    end

    // ==========================================================
    // Timing counters
    dps_state_t  state_r;
    logic [2:0]  cur_op_r;
    logic [15:0] gap_r;        // general next-command hold
    logic [15:0] lock_r;       // DLL lock, gates reads
    logic [15:0] lowp_hold_r;  // power request must stay high
    logic [15:0] mode_gap_r;   // data burst to mode load
    logic [15:0] ckd_r;
    logic [15:0] win_r;
    logic [15:0] refi_r;
    logic        dll_need_r;
    logic [3:0]  burst_r;
    logic        ref_due;
    logic        is_first;
    logic        done_refc;
    logic        sref_exit;

    // A due refresh still waits out the hold of the command before it
    assign ref_due  = auto_ref_en_r && refi_r == 16'h0000 && gap_r == 16'h0000;
    assign op_taken = state_r == DPS_IDLE && op_pend_r && gap_r == 16'h0000 && !ref_due
                      && op_r != OP_NONE
                      && !(op_r == OP_READ && lock_r != 16'h0000)
                      && !((op_r == OP_MODE || op_r == OP_EXT_MODE) && mode_gap_r != 16'h0000)
                      && !((op_r == OP_POWERDOWN || op_r == OP_SELFREF) && lowp_hold_r != 16'h0000);
    assign is_first = state_r == DPS_FIRST;
    assign done_refc = state_r == DPS_WAIT && gap_r == 16'h0000;
    // Wake-up from self-refresh only once the clock has run again for a cycle
    assign sref_exit = state_r == DPS_SREF && op_pend_r && op_r == OP_NONE && !clk_stop_r && mem_clk_en;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_r  <= DPS_IDLE;
            cur_op_r <= OP_NONE;
        end else begin
            unique case (state_r)
                DPS_IDLE: begin
                    if (ref_due) begin
                        state_r  <= DPS_FIRST;
                        cur_op_r <= OP_REFRESH;
                    end else if (op_taken) begin
                        cur_op_r <= op_r;
                        state_r  <= op_r == OP_POWERDOWN ? DPS_PDOWN : DPS_FIRST;
                    end
                end
                DPS_FIRST: state_r <= DPS_SECND;
                DPS_SECND: state_r <= cur_op_r == OP_SELFREF ? DPS_SREF : DPS_IDLE;
                DPS_PDOWN: begin
                    // Leave on software request or before refresh interval runs out
                    if (op_pend_r && op_r == OP_NONE || refi_r < {t_pda_r[14:0], 1'b0})
                        state_r <= DPS_IDLE;
                end
                DPS_SREF: begin
                    // Exit waits for a running clock, never for a clock just restarted
                    if (sref_exit) begin
                        state_r  <= DPS_WAIT;
                        cur_op_r <= OP_NONE;
                    end
                end
                DPS_WAIT: begin
                    if (done_refc) begin
                        state_r  <= DPS_FIRST;
                        cur_op_r <= OP_REFRESH;
                    end
                end
                default: state_r <= DPS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            gap_r <= 16'h0000;
        end else if (state_r == DPS_SECND && (cur_op_r == OP_REFRESH || cur_op_r == OP_SELFREF)) begin
            gap_r <= t_refc_r;
        end else if (state_r == DPS_SECND && (cur_op_r == OP_MODE || cur_op_r == OP_EXT_MODE)) begin
            gap_r <= t_rsc_r;
        end else if (state_r == DPS_PDOWN) begin
            // Reloaded every power-down cycle so the full count starts when the pin rises
            gap_r <= t_pda_r;
        end else if (sref_exit) begin
            gap_r <= t_refc_r;
        end else if (gap_r != 16'h0000) begin
            gap_r <= gap_r - 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lock_r     <= 16'h0000;
            dll_need_r <= 1'b1;
        end else if (state_r == DPS_SECND && cur_op_r == OP_EXT_MODE && dll_need_r) begin
            lock_r     <= t_lock_r;
            dll_need_r <= 1'b0;
        end else if (sref_exit) begin
            // The DLL has to lock again after self-refresh before any read
            lock_r <= t_lock_r;
        end else if (lock_r != 16'h0000) begin
            lock_r <= lock_r - 16'h0001;
        end
    end

    // Data-burst holds, loaded at the address-latch command
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lowp_hold_r <= 16'h0000;
            mode_gap_r  <= 16'h0000;
        end else if (state_r == DPS_SECND && cur_op_r == OP_READ) begin
            lowp_hold_r <= {12'h000, read_lat + half_bl};
            mode_gap_r  <= {12'h000, read_lat + half_bl};
        end else if (state_r == DPS_SECND && cur_op_r == OP_WRITE) begin
            lowp_hold_r <= {12'h000, write_lat + 4'(WRITE_EXTRA_CYC)};
            mode_gap_r  <= {12'h000, write_lat + half_bl};
        end else begin
            if (lowp_hold_r != 16'h0000)
                lowp_hold_r <= lowp_hold_r - 16'h0001;
            if (mode_gap_r != 16'h0000)
                mode_gap_r <= mode_gap_r - 16'h0001;
        end
    end

    // Refresh pacing: interval fixed at the average, so eight never bunch up
    // Held still in self-refresh, where the device keeps its own refresh timer
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            refi_r <= 16'(REFRESH_INTERVAL);
        end else if (state_r == DPS_SECND && (cur_op_r == OP_REFRESH || cur_op_r == OP_SELFREF)) begin
            refi_r <= 16'(REFRESH_INTERVAL);
        end else if (refi_r != 16'h0000 && state_r != DPS_SREF) begin
            refi_r <= refi_r - 16'h0001;
        end
    end

    // Self-refresh entry: request low inside window, clock held afterwards
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            win_r <= 16'h0000;
            ckd_r <= 16'h0000;
        end else if (state_r == DPS_SECND && cur_op_r == OP_SELFREF) begin
            win_r <= t_window_r;
            ckd_r <= t_ckd_r;
        end else begin
            if (win_r != 16'h0000)
                win_r <= win_r - 16'h0001;
            if (ckd_r != 16'h0000)
                ckd_r <= ckd_r - 16'h0001;
        end
    end

    // ==========================================================
    // Pin drive
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            chip_select_n       <= CS_DESEL;
            function_control    <= 1'b1;
            bank_addr           <= 2'h0;
            mem_addr            <= 15'h0000;
            low_power_request_n <= 1'b1;
            mem_clk_en          <= 1'b1;
        end else begin
            // Deselect by default on every cycle outside the two command parts
            chip_select_n    <= CS_DESEL;
            function_control <= 1'b1;
            if (is_first) begin
                chip_select_n    <= CS_SEL;
                function_control <= (cur_op_r == OP_READ || cur_op_r == OP_MODE
                                     || cur_op_r == OP_EXT_MODE) ? FN_READ_ACT : FN_WRITE_ACT;
                bank_addr        <= cur_op_r == OP_EXT_MODE ? BANK_EXT
                                    : cur_op_r == OP_MODE ? BANK_REGULAR : cmd_bank_r;
                mem_addr         <= cur_op_r == OP_EXT_MODE ? ext_data_r : cmd_upper_r;
            end else if (state_r == DPS_SECND) begin
                chip_select_n    <= CS_SEL;
                function_control <= (cur_op_r == OP_READ || cur_op_r == OP_WRITE) ? FN_LAL : FN_REF;
                mem_addr         <= cmd_lower_r;
            end
            // Request low in power-down while no wake-up order and the interval allows, or with the second part of self-refresh
            if (state_r == DPS_PDOWN && !(op_pend_r && op_r == OP_NONE)
                && refi_r >= {t_pda_r[14:0], 1'b0})
                low_power_request_n <= 1'b0;
            else if (state_r == DPS_SECND && cur_op_r == OP_SELFREF)
                low_power_request_n <= 1'b0;
            else if (state_r != DPS_SREF)
                low_power_request_n <= 1'b1;
            else if (sref_exit)
                low_power_request_n <= 1'b1;
            // Clock may stop only in self-refresh after the hold period
            mem_clk_en <= !(state_r == DPS_SREF && clk_stop_r && ckd_r == 16'h0000);
        end
    end

    // Write strobe: toggles for every write burst beat regardless of masks
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            burst_r <= 4'h0;
        end else if (state_r == DPS_SECND && cur_op_r == OP_WRITE) begin
            burst_r <= write_lat + half_bl;
        end else if (burst_r != 4'h0) begin
            burst_r <= burst_r - 4'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            write_strobe_in <= 1'b0;
            write_strobe_oe <= 1'b0;
        end else begin
            write_strobe_oe <= burst_r != 4'h0 && burst_r <= half_bl;
            write_strobe_in <= burst_r != 4'h0 && burst_r <= half_bl && !write_strobe_in;
        end
    end

    // ==========================================================
    // Read port
    // Data is zero outside the cycle after a read strobe
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (reg_addr)
            REG_CTRL:     rdata_nxt = {30'h0000_0000, clk_stop_r, auto_ref_en_r};
            REG_STATUS:   rdata_nxt = {22'h00_0000, lock_r != 16'h0000, gap_r != 16'h0000,
                                       dll_need_r, op_pend_r, 1'b0, state_r, !low_power_request_n,
                                       win_r != 16'h0000};
            REG_CMD:      rdata_nxt = {29'h0000_0000, op_r};
            REG_T_REFC:   rdata_nxt = {16'h0000, t_refc_r};
            REG_T_PDA:    rdata_nxt = {16'h0000, t_pda_r};
            REG_T_LOCK:   rdata_nxt = {16'h0000, t_lock_r};
            REG_T_RSC:    rdata_nxt = {16'h0000, t_rsc_r};
            REG_T_WINDOW: rdata_nxt = {16'h0000, t_window_r};
            REG_T_CKD:    rdata_nxt = {16'h0000, t_ckd_r};
            REG_LAT:      rdata_nxt = {16'h0000, lat_r};
            REG_EXT_DATA: rdata_nxt = {17'h0_0000, ext_data_r};
            default:      rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            reg_rdata <= 32'h0000_0000;
        else
            reg_rdata <= reg_rd ? rdata_nxt : 32'h0000_0000;
    end
endmodule
`default_nettype wire

// ===== test/dps_ctrl_chk.sv
// Checker: pin sequencing of the power and refresh sequencer
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Command spacing and power request checks
module dps_ctrl_chk
    import dps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic mem_clk_en,
    input wire logic chip_select_n,
    input wire logic function_control,
    input wire logic low_power_request_n
);
    logic       p_sel_r;
    logic       p_fn_r;
    logic [7:0] since_ref_r;
    wire logic  sel   = !chip_select_n;
    wire logic  lower_address_latch_cmd   = sel && function_control && p_sel_r;
    wire logic  ref2  = sel && !function_control && p_sel_r && !p_fn_r;
    wire logic  mode2 = sel && !function_control && p_sel_r && p_fn_r;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Saturates so that a refresh long ago never wraps into a false gap
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            {p_sel_r, p_fn_r, since_ref_r} <= {2'h1, 8'hFF};
        end else begin
            {p_sel_r, p_fn_r} <= {sel, function_control};
            since_ref_r <= ref2 ? 8'h01 : since_ref_r + {7'h00, since_ref_r != 8'hFF};
        end
    end
    chk_cmd_pair: assert property (sel && !p_sel_r |=> sel)
        else $error("second command part missing");
    chk_wr_hold: assert property (lower_address_latch_cmd && !p_fn_r |=> low_power_request_n [*5])
        else $error("request low too soon after write");
    chk_rd_hold: assert property (lower_address_latch_cmd && p_fn_r |=> low_power_request_n [*6])
        else $error("request low during read burst");
    chk_mode_gap: assert property (lower_address_latch_cmd && p_fn_r |=> !mode2 [*6])
        else $error("mode load too soon after read");
    chk_exit_desel: assert property ($rose(low_power_request_n) |-> chip_select_n [*4])
        else $error("command too soon after power exit");
    chk_clk_exit: assert property ($rose(low_power_request_n) |-> mem_clk_en && $past(mem_clk_en))
        else $error("clock not stable at exit");
    chk_low_quiet: assert property (!low_power_request_n && $past(!low_power_request_n) |-> chip_select_n)
        else $error("command while request low");
    chk_ref_gap: assert property (sel && !p_sel_r |-> since_ref_r >= 8'h13)
        else $error("command inside refresh cycle");
endmodule
bind dps_ctrl dps_ctrl_chk dps_ctrl_chk_i (.clk_sys(clk_sys), .rst_b(rst_b), .mem_clk_en(mem_clk_en),
    .chip_select_n(chip_select_n), .function_control(function_control), .low_power_request_n(low_power_request_n));
`default_nettype wire

// ===== test/dps_mem_model.sv
// Behavioural model of the memory device: power modes and command acceptance
`timescale 1ns/10ps
`default_nettype none
// ============================
// Device power state tracker
module dps_mem_model
    import dps_pkg::*;
#(
    parameter int REFC = 19,
    parameter int PDA  = 4,
    parameter int LOCK = 200,
    parameter int WIN  = 2
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       mem_clk_en,
    input  wire logic       chip_select_n,
    input  wire logic       function_control,
    input  wire logic       low_power_request_n,
    output logic      [1:0] power_mode,
    output int              viol_count
);
    logic p_sel, p_fn;
    int   busy, win, lock;
    // Exit needs no sampled clock edge, so it has its own event
    always @(posedge low_power_request_n) begin
        if (power_mode != 2'h0) begin
            busy = (power_mode == 2'h2) ? REFC - 1 : PDA - 1;
            lock = (power_mode == 2'h2) ? LOCK - 1 : 0;
            power_mode = 2'h0;
        end
    end
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            {p_sel, p_fn, power_mode, busy, win, lock, viol_count} = 132'h0;
        end else if (power_mode == 2'h0 && mem_clk_en) begin
            viol_count += (!chip_select_n && busy > 0) ? 1 : 0;
            viol_count += (!chip_select_n && function_control && p_sel && p_fn && lock > 0) ? 1 : 0;
            busy -= (busy > 0) ? 1 : 0;
            win  -= (win > 0) ? 1 : 0;
            lock -= (lock > 0) ? 1 : 0;
            if (!chip_select_n && !function_control && p_sel && !p_fn) begin
                busy = REFC - 1;
                win  = WIN + 2;
            end
            // The undecided zone between the window and the valid limit is taken as self-refresh
            if (!low_power_request_n) power_mode = (win > 0) ? 2'h2 : 2'h1;
            {p_sel, p_fn} = {!chip_select_n, function_control};
        end
    end
endmodule
`default_nettype wire

// ===== test/dps_ctrl_tb.sv
// Testbench for the power and refresh sequencer
`timescale 1ns/10ps
`default_nettype none
// =========================
// Register-driven scenarios
module dps_ctrl_tb;
    import dps_pkg::*;
    // Long enough that power-down is entered well before the interval runs out
    localparam int RI = 120;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] d;
    logic        f1, f2;
    int          checks = 0, fail_count = 0, cyc = 0, viol;
    wire logic [31:0] reg_rdata;
    wire logic [1:0]  pm, ba;
    wire logic        cen, csn, fnc, lprn;
    logic [15:0] rst_tab [7] = '{T_REFC_RST, T_PDA_RST, T_LOCK_RST, T_RSC_RST, T_WINDOW_RST, T_CKD_RST, LAT_RST};
    logic [2:0]  ops [5] = '{OP_READ, OP_WRITE, OP_REFRESH, OP_MODE, OP_EXT_MODE};
    logic        fa [5] = '{FN_READ_ACT, FN_WRITE_ACT, FN_WRITE_ACT, FN_READ_ACT, FN_READ_ACT};
    logic        fb [5] = '{FN_LAL, FN_LAL, FN_REF, FN_REF, FN_REF};
    always #10 clk_sys = ~clk_sys;
    dps_ctrl #(.REFRESH_INTERVAL(RI)) dps_ctrl_i (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_clk_en(cen),
        .chip_select_n(csn), .function_control(fnc), .bank_addr(ba), .mem_addr(), .low_power_request_n(lprn),
        .write_strobe_in(), .write_strobe_oe());
    dps_mem_model dps_mem_model_i (.clk_sys(clk_sys), .rst_b(rst_b), .mem_clk_en(cen), .chip_select_n(csn),
        .function_control(fnc), .low_power_request_n(lprn), .power_mode(pm), .viol_count(viol));
    task automatic end_of_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // A command word is refused while one is pending, so wait for the pending flag first
    task automatic op(input logic [2:0] c, input logic [1:0] b);
        for (int n = 0; n < 300; n++) begin
            rd(REG_STATUS);
            if (d[6] === 1'b0) break;
        end
        wr(REG_CMD, {4'h0, b, 23'h00_0000, c});
    endtask
    task automatic cmd();
        for (int n = 0; n < 600 && csn !== 1'b0; n++) @(posedge clk_sys) #1;
        f1 = fnc;
        @(posedge clk_sys) #1 f2 = fnc;
        chk("command seen", 32'h0000_0000, {31'h0, csn});
    endtask
    task automatic lvl(input logic v, input int lim);
        for (int n = 0; n < lim && lprn !== v; n++) @(posedge clk_sys) #1;
        chk("power request", {31'h0, v}, {31'h0, lprn});
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        wr(REG_CTRL, 32'h0000_0000);
        for (int i = 0; i < 7; i++) begin
            rd(4'(i + 3));
            chk("timing reset", {16'h0000, rst_tab[i]}, d);
        end
        rd(4'hB);
        wr(REG_EXT_DATA, 32'h0000_0001);
        rd(REG_EXT_DATA);
        chk("dll switch", 32'h0000_0000, {31'h0, d[0]});
        for (int i = 0; i < 5; i++) begin
            op(ops[i], (i == 4) ? BANK_EXT : BANK_REGULAR);
            cmd();
            chk("first part", {31'h0, fa[i]}, {31'h0, f1});
            chk("second part", {31'h0, fb[i]}, {31'h0, f2});
            chk("bank select", {30'h0, (i == 4) ? BANK_EXT : BANK_REGULAR}, {30'h0, ba});
        end
        op(OP_WRITE, BANK_REGULAR);
        op(OP_POWERDOWN, BANK_REGULAR);
        lvl(1'b0, 300);
        @(posedge clk_sys) #1 chk("power-down mode", 32'h0000_0001, {30'h0, pm});
        lvl(1'b1, RI + 40);
        op(OP_READ, BANK_REGULAR);
        op(OP_SELFREF, BANK_REGULAR);
        lvl(1'b0, 300);
        @(posedge clk_sys) #1 chk("self-refresh mode", 32'h0000_0002, {30'h0, pm});
        repeat (20) @(posedge clk_sys);
        op(OP_NONE, BANK_REGULAR);
        lvl(1'b1, 300);
        cmd();
        chk("refresh after exit", {30'h0, FN_WRITE_ACT, FN_REF}, {30'h0, f1, f2});
        op(OP_READ, BANK_REGULAR);
        cmd();
        chk("read after lock", {30'h0, FN_READ_ACT, FN_LAL}, {30'h0, f1, f2});
        wr(REG_CTRL, 32'h0000_0001);
        cmd();
        chk("paced refresh", {30'h0, FN_WRITE_ACT, FN_REF}, {30'h0, f1, f2});
        chk("device violations", 32'h0000_0000, 32'(viol));
        end_of_test();
    end
endmodule
`default_nettype wire
